//--- design/qtbp_pkg.sv
package qtbp_pkg;

    // apb address decode: paddr carries a byte address, one word per entry
    localparam int ADDR_W = 12;
    localparam int IDX_W = 9;
    localparam int DATA_W = 32;

    // query table indices, byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_OTP_GROUPS_LOW = 9'h124;
    localparam logic [IDX_W-1:0] IDX_OTP_GROUPS_HIGH = 9'h125;
    localparam logic [IDX_W-1:0] IDX_OTP_BYTES_PER_GROUP = 9'h126;
    localparam logic [IDX_W-1:0] IDX_PAGE_READ_CAPABILITY = 9'h127;
    localparam logic [IDX_W-1:0] IDX_SYNC_READ_FIELD_COUNT = 9'h128;
    localparam logic [IDX_W-1:0] IDX_BURST_CAPABILITY_ONE = 9'h129;
    localparam logic [IDX_W-1:0] IDX_BURST_CAPABILITY_TWO = 9'h12a;
    localparam logic [IDX_W-1:0] IDX_BURST_CAPABILITY_THREE = 9'h12b;
    localparam logic [IDX_W-1:0] IDX_PARTITION_REGION_COUNT = 9'h12c;

    // local control and status words
    localparam logic [IDX_W-1:0] IDX_QUERY_CTRL = 9'h140;
    localparam logic [IDX_W-1:0] IDX_READ_CONFIG_REG = 9'h141;
    localparam logic [IDX_W-1:0] IDX_BURST_STATUS = 9'h142;
    localparam logic [IDX_W-1:0] IDX_QUERY_READ_COUNT = 9'h143;

    // fixed query bytes
    localparam logic [7:0] VAL_OTP_GROUPS_LOW = 8'h10;
    localparam logic [7:0] VAL_OTP_GROUPS_HIGH = 8'h00;
    localparam logic [7:0] VAL_OTP_BYTES_PER_GROUP = 8'h04;
    localparam logic [7:0] VAL_PAGE_NON_MUX = 8'h05;
    localparam logic [7:0] VAL_PAGE_AD_MUX = 8'h00;
    localparam logic [7:0] VAL_SYNC_READ_FIELD_COUNT = 8'h03;
    localparam logic [7:0] VAL_BURST_CAPABILITY_ONE = 8'h02;
    localparam logic [7:0] VAL_BURST_CAPABILITY_TWO = 8'h03;
    localparam logic [7:0] VAL_BURST_CAPABILITY_THREE = 8'h07;
    localparam logic [7:0] VAL_PARTITION_REGION_COUNT = 8'h01;

    // table as parallel arrays, page entry is patched for the mux variant
    localparam int QT_N = 9;
    localparam int QT_PAGE_ENTRY = 3;
    localparam logic [IDX_W-1:0] QT_IDX [QT_N] = '{
        IDX_OTP_GROUPS_LOW, IDX_OTP_GROUPS_HIGH, IDX_OTP_BYTES_PER_GROUP,
        IDX_PAGE_READ_CAPABILITY, IDX_SYNC_READ_FIELD_COUNT,
        IDX_BURST_CAPABILITY_ONE, IDX_BURST_CAPABILITY_TWO,
        IDX_BURST_CAPABILITY_THREE, IDX_PARTITION_REGION_COUNT};
    localparam logic [7:0] QT_VAL [QT_N] = '{
        VAL_OTP_GROUPS_LOW, VAL_OTP_GROUPS_HIGH, VAL_OTP_BYTES_PER_GROUP,
        VAL_PAGE_NON_MUX, VAL_SYNC_READ_FIELD_COUNT,
        VAL_BURST_CAPABILITY_ONE, VAL_BURST_CAPABILITY_TWO,
        VAL_BURST_CAPABILITY_THREE, VAL_PARTITION_REGION_COUNT};

    // burst capability code layout
    localparam int BURST_CODE_W = 3;
    localparam logic [BURST_CODE_W-1:0] BURST_CODE_CONT = 3'h7;

    // control word fields
    localparam int CTRL_MUX_BIT = 0;
    localparam int CTRL_CLR_CNT_BIT = 1;

    // burst status word fields
    localparam int STAT_WORDS_LSB = 0;
    localparam int STAT_CONT_BIT = 8;
    localparam int STAT_ADV_BIT = 9;

    // reset values
    localparam logic RST_MUX_VARIANT = 1'b0;
    localparam logic [BURST_CODE_W-1:0] RST_READ_CONFIG = 3'h7;
    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] RST_QUERY_READ_COUNT = 16'h0000;

endpackage : qtbp_pkg

//--- design/qtbp_rd_if.sv
`timescale 1ns/1ns
`default_nettype none

// lookup request from the bus slave to the query table
interface qtbp_rd_if;
    logic [qtbp_pkg::IDX_W-1:0] index;
    logic mux_variant;
    logic [7:0] data;
    logic hit;

    modport ctrl (output index, output mux_variant, input data, input hit);
    modport table_side (input index, input mux_variant, output data,
        output hit);
endinterface : qtbp_rd_if

`default_nettype wire

//--- design/qtbp_query_rom.sv
`timescale 1ns/1ns
`default_nettype none

module qtbp_query_rom (
    qtbp_rd_if.table_side rd
);
    logic [qtbp_pkg::QT_N-1:0] match;
    logic [7:0] masked [qtbp_pkg::QT_N];

    // one comparator per entry; unmatched entries contribute zero
    for (genvar i = 0; i < qtbp_pkg::QT_N; i++) begin : g_entry
        logic [7:0] val;
        if (i == qtbp_pkg::QT_PAGE_ENTRY) begin : g_page
            // no page buffer exists on the multiplexed variant
            assign val = rd.mux_variant ? qtbp_pkg::VAL_PAGE_AD_MUX
                : qtbp_pkg::VAL_PAGE_NON_MUX; // RULE_01 RULE_02
        end else begin : g_fixed
            // RULE_03 RULE_07 RULE_08 RULE_09
            assign val = qtbp_pkg::QT_VAL[i];
        end
        assign match[i] = (rd.index == qtbp_pkg::QT_IDX[i]);
        assign masked[i] = match[i] ? val : 8'h00;
    end

    // or-reduce the masked entries, indices are unique
    always_comb begin
        rd.data = 8'h00;
        for (int j = 0; j < qtbp_pkg::QT_N; j++) begin
            rd.data = rd.data | masked[j];
        end
    end

    assign rd.hit = |match;

endmodule : qtbp_query_rom

`default_nettype wire

//--- design/qtbp_burst_dec.sv
`timescale 1ns/1ns
`default_nettype none

module qtbp_burst_dec (
    input wire logic [2:0] code_i,
    output logic [7:0] words_o,
    output logic cont_o,
    output logic advertised_o
);
    // code n gives 2^(n+1) words, code 7 runs to the end of burst space
    always_comb begin
        cont_o = (code_i == qtbp_pkg::BURST_CODE_CONT); // RULE_05
        words_o = cont_o ? 8'h00 : 8'(8'h02 << code_i); // RULE_04
        // only codes the query table offers are safe to program
        advertised_o = (code_i == qtbp_pkg::VAL_BURST_CAPABILITY_ONE[2:0])
            || (code_i == qtbp_pkg::VAL_BURST_CAPABILITY_TWO[2:0])
            || (code_i == qtbp_pkg::VAL_BURST_CAPABILITY_THREE[2:0]);
    end

endmodule : qtbp_burst_dec

`default_nettype wire

//--- design/qtbp_query_bank.sv
// Contract
// RULE_01: the page byte is an exponent n giving 2^n page bytes, zero meaning no page buffer.
// RULE_02: the page byte reads 05 on the non-multiplexed variant and 00 on the multiplexed one.
// RULE_03: the field-count byte reports three synchronous read capability fields.
// RULE_04: each capability field holds a 3-bit code n in its low bits, burst length 2^(n+1) words.
// RULE_05: a code of seven means continuous linear bursting to the end of burst space.
// RULE_06: the host may copy a capability code unchanged into the read config register low bits.
// RULE_07: the three capability fields read 02, 03 and 07.
// RULE_08: the partition-region count gives the region count, zero meaning a single partition.
// RULE_09: the otp tail reads 10 and 00 for the group count and 04 for bytes per group.
// RULE_10: every query byte sits on data bits 7:0 with the upper bits read as zero.
`timescale 1ns/1ns
`default_nettype none

module qtbp_query_bank (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [qtbp_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [qtbp_pkg::DATA_W-1:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [qtbp_pkg::DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic [2:0] read_config_o,
    output logic mux_variant_o
);

    // whole register state of the bank
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [qtbp_pkg::DATA_W-1:0] prdata;
        logic mux_variant;
        logic [qtbp_pkg::BURST_CODE_W-1:0] read_config_reg;
        logic [qtbp_pkg::CNT_W-1:0] query_reads;
    } qtbp_state_t;

    qtbp_state_t st;
    qtbp_state_t next_st;

    qtbp_rd_if rd_if ();

    logic [qtbp_pkg::IDX_W-1:0] idx;
    logic addr_ok;
    logic access;
    logic finish;
    logic sel_ctrl;
    logic sel_rcfg;
    logic sel_stat;
    logic sel_cnt;
    logic [7:0] burst_words;
    logic burst_cont;
    logic burst_adv;
    logic [qtbp_pkg::DATA_W-1:0] rd_word;
    logic rd_err;
    logic wr_err;

    // word index from the byte address; upper bit and low bits must be zero
    assign idx = paddr_i[qtbp_pkg::IDX_W+1:2];
    assign addr_ok = (paddr_i[1:0] == 2'h0)
        && (paddr_i[qtbp_pkg::ADDR_W-1] == 1'b0);

    // the table lookup runs on the live address, ready is a cycle late
    assign rd_if.index = idx;
    assign rd_if.mux_variant = st.mux_variant;

    qtbp_query_rom u_rom (
        .rd(rd_if)
    );

    // decoded view of the programmed read config code
    qtbp_burst_dec u_dec (
        .code_i(st.read_config_reg),
        .words_o(burst_words),
        .cont_o(burst_cont),
        .advertised_o(burst_adv)
    );

    // local word selects
    assign sel_ctrl = addr_ok && (idx == qtbp_pkg::IDX_QUERY_CTRL);
    assign sel_rcfg = addr_ok && (idx == qtbp_pkg::IDX_READ_CONFIG_REG);
    assign sel_stat = addr_ok && (idx == qtbp_pkg::IDX_BURST_STATUS);
    assign sel_cnt = addr_ok && (idx == qtbp_pkg::IDX_QUERY_READ_COUNT);

    // access phase waiting for its answer, and the completing edge
    assign access = psel_i && penable_i && !st.pready;
    assign finish = psel_i && penable_i && st.pready;

    // read data mux; query bytes go out on the low lane only
    always_comb begin
        rd_word = '0;
        rd_err = 1'b0;
        if (addr_ok && rd_if.hit) begin
            rd_word = {24'h000000, rd_if.data}; // RULE_10
        end else if (sel_ctrl) begin
            rd_word[qtbp_pkg::CTRL_MUX_BIT] = st.mux_variant;
        end else if (sel_rcfg) begin
            rd_word[qtbp_pkg::BURST_CODE_W-1:0] = st.read_config_reg;
        end else if (sel_stat) begin
            rd_word[qtbp_pkg::STAT_WORDS_LSB +: 8] = burst_words; // RULE_04
            rd_word[qtbp_pkg::STAT_CONT_BIT] = burst_cont; // RULE_05
            rd_word[qtbp_pkg::STAT_ADV_BIT] = burst_adv;
        end else if (sel_cnt) begin
            rd_word[qtbp_pkg::CNT_W-1:0] = st.query_reads;
        end else begin
            rd_err = 1'b1;
        end
    end

    // writes land only on the two local control words; the table is fixed
    always_comb begin
        wr_err = 1'b1;
        if (sel_ctrl || sel_rcfg) begin
            wr_err = 1'b0;
        end
    end

    // next state: bus handshake, control writes, query read counting
    always_comb begin
        next_st = st;
        if (access) begin
            // answer one cycle into the access phase
            next_st.pready = 1'b1;
            if (pwrite_i) begin
                next_st.pslverr = wr_err;
                next_st.prdata = '0;
            end else begin
                next_st.pslverr = rd_err;
                next_st.prdata = rd_err ? '0 : rd_word;
            end
        end else if (finish) begin
            // transfer done at this edge; drop the answer
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
            next_st.prdata = '0;
            if (pwrite_i && !wr_err && pstrb_i[0]) begin
                if (sel_ctrl) begin
                    next_st.mux_variant = pwdata_i[qtbp_pkg::CTRL_MUX_BIT];
                end
                if (sel_rcfg) begin
                    // code copied unchanged from a capability field
                    next_st.read_config_reg =
                        pwdata_i[qtbp_pkg::BURST_CODE_W-1:0]; // RULE_06
                end
            end
            // counter clear wins over a count in the same transfer
            if (pwrite_i && sel_ctrl && pstrb_i[0]
                    && pwdata_i[qtbp_pkg::CTRL_CLR_CNT_BIT]) begin
                next_st.query_reads = qtbp_pkg::RST_QUERY_READ_COUNT;
            end else if (!pwrite_i && addr_ok && rd_if.hit) begin
                // saturate so a long poll loop cannot wrap to zero
                if (st.query_reads != {qtbp_pkg::CNT_W{1'b1}}) begin
                    next_st.query_reads = st.query_reads + 16'h0001;
                end
            end
        end else begin
            next_st.pready = 1'b0;
            next_st.pslverr = 1'b0;
        end
    end

    // single register for all state; clock enable freezes everything except the synchronous reset, which loads even with ce_i low
    always_ff @(posedge mclk_i) begin
        if (!rstn_i) begin
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.prdata <= '0;
            st.mux_variant <= qtbp_pkg::RST_MUX_VARIANT;
            st.read_config_reg <= qtbp_pkg::RST_READ_CONFIG;
            st.query_reads <= qtbp_pkg::RST_QUERY_READ_COUNT;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // outputs come straight from the state register
    assign prdata_o = st.prdata;
    assign pready_o = st.pready;
    assign pslverr_o = st.pslverr;
    assign read_config_o = st.read_config_reg;
    assign mux_variant_o = st.mux_variant;

endmodule : qtbp_query_bank

`default_nettype wire

//--- dv/qtbp_query_bank_properties.sv
`timescale 1ns/1ns
`default_nettype none

// watches the bank's bus ports and ties each answer to its address
module qtbp_query_bank_properties (
    input wire logic mclk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [2:0] read_config_o,
    input wire logic mux_variant_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    // an accepted read; data only counts in this cycle
    wire rd_ok = psel_i && penable_i && pready_o && !pwrite_i && !pslverr_o;

    a_one_wait: assert property (
        psel_i && penable_i && !pready_o && ce_i |=> pready_o)
        else $error("answer not one cycle after access");
    a_ready_pulse: assert property (
        pready_o && ce_i |=> !pready_o) else $error("ready held too long");
    a_upper_zero: assert property (
        rd_ok && paddr_i[11:8] == 4'h4 |-> prdata_o[31:8] == 24'h0)
        else $error("upper data lines not zero");
    a_page_byte: assert property (
        rd_ok && paddr_i == 12'h49c |->
        prdata_o == (mux_variant_o ? 32'h0 : 32'h5))
        else $error("page byte wrong for variant");
    a_field_count: assert property (
        rd_ok && paddr_i == 12'h4a0 |-> prdata_o == 32'h3)
        else $error("field count wrong");
    a_burst_codes: assert property (
        rd_ok && paddr_i inside {12'h4a4, 12'h4a8, 12'h4ac} |->
        prdata_o == ((paddr_i == 12'h4a4) ? 32'h2 :
        (paddr_i == 12'h4a8) ? 32'h3 : 32'h7))
        else $error("burst code wrong");
    a_burst_len: assert property (
        rd_ok && paddr_i == 12'h508 && read_config_o != 3'h7 |->
        prdata_o[7:0] == (8'h1 << (read_config_o + 3'h1)))
        else $error("burst length not two to n plus one");
    a_cont_burst: assert property (
        rd_ok && paddr_i == 12'h508 && read_config_o == 3'h7 |->
        prdata_o[8] && prdata_o[7:0] == 8'h0)
        else $error("code seven not continuous");
    a_partition: assert property (
        rd_ok && paddr_i == 12'h4b0 |-> prdata_o == 32'h1)
        else $error("partition count wrong");
    a_otp_tail: assert property (
        rd_ok && paddr_i inside {12'h490, 12'h494, 12'h498} |->
        prdata_o == ((paddr_i == 12'h490) ? 32'h10 :
        (paddr_i == 12'h494) ? 32'h0 : 32'h4))
        else $error("otp tail wrong");

    c_page_mux: cover property (rd_ok && paddr_i == 12'h49c && mux_variant_o);
    c_cont: cover property (rd_ok && paddr_i == 12'h508
        && read_config_o == 3'h7);
    c_refused: cover property (pready_o && pslverr_o);
endmodule : qtbp_query_bank_properties

bind qtbp_query_bank qtbp_query_bank_properties u_props (.mclk_i, .rstn_i,
    .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .prdata_o, .pready_o,
    .pslverr_o, .read_config_o, .mux_variant_o);

`default_nettype wire

//--- dv/qtbp_host_model.sv
`timescale 1ns/1ns
`default_nettype none

// host side bus master; changes its lines only just after a rising edge
module qtbp_host_model (
    input wire logic mclk_i,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [11:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o
);
    // idle bus at time zero
    initial begin
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        pwrite_o <= 1'b0;
        paddr_o <= 12'h0;
        pwdata_o <= 32'h0;
        pstrb_o <= 4'h0;
    end

    // ready is sampled at the rising edge; data and error are taken there
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] rd, output logic err,
        output logic tmo);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= 4'hf;
        @(posedge mclk_i);
        penable_o <= 1'b1;
        @(posedge mclk_i);
        while (!pready_i && n < 40) begin
            @(posedge mclk_i);
            n++;
        end
        // the request is released only at the edge that completed it
        rd = prdata_i;
        err = pslverr_i;
        tmo = !pready_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        // released lines must not look like a held request
        paddr_o <= ~a;
        pwdata_o <= ~d;
        pstrb_o <= 4'h0;
    endtask : xfer
endmodule : qtbp_host_model

`default_nettype wire

//--- dv/tb_query_table_burst_partition_info.sv
`timescale 1ns/1ns
`default_nettype none

module tb_query_table_burst_partition_info;
    logic mclk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic ce_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, mux_v, err, tmo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, got;
    logic [3:0] pstrb;
    logic [2:0] rcfg;
    int num_errors = 0;
    int cmp_count = 0;

    // 125 MHz bus clock
    initial begin
        forever #4 mclk_i = ~mclk_i;
    end

    qtbp_query_bank dut (.mclk_i, .rstn_i, .ce_i, .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .read_config_o(rcfg),
        .mux_variant_o(mux_v));
    qtbp_host_model host (.mclk_i, .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable),
        .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
        .pstrb_o(pstrb));

    task automatic test_done;
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic check(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check

    // one transfer; a slave that never answers ends the run
    task automatic bus(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        host.xfer(w, a, d, got, err, tmo);
        if (tmo) begin
            num_errors++;
            test_done();
        end
    endtask : bus

    task automatic rd(input logic [11:0] a, input logic [31:0] exp,
        input logic e);
        bus(1'b0, a, 32'h0);
        check("rdata", got, exp);
        check("slverr", {31'h0, err}, {31'h0, e});
    endtask : rd

    // every query byte in turn, byte on the low lines only
    task automatic t_table;
        logic [31:0] v [9] = '{32'h10, 32'h00, 32'h04, 32'h05, 32'h03,
            32'h02, 32'h03, 32'h07, 32'h01};
        for (int i = 0; i < 9; i++) begin
            rd(12'h490 + 12'(4 * i), v[i], 1'b0);
        end
    endtask : t_table

    // multiplexed variant loses the page buffer, and gets it back
    task automatic t_variant;
        bus(1'b1, 12'h500, 32'h1);
        @(negedge mclk_i);
        check("mux", {31'h0, mux_v}, 32'h1);
        rd(12'h49c, 32'h0, 1'b0);
        bus(1'b1, 12'h500, 32'h0);
        rd(12'h49c, 32'h5, 1'b0);
    endtask : t_variant

    // host copies each advertised code, then one code not advertised
    task automatic t_copy;
        logic [2:0] cl [4] = '{3'h2, 3'h3, 3'h7, 3'h5};
        logic [2:0] c;
        logic [31:0] s;
        for (int i = 0; i < 4; i++) begin
            c = cl[i];
            if (i < 3) begin
                rd(12'h4a4 + 12'(4 * i), {29'h0, c}, 1'b0);
                c = got[2:0];
            end
            bus(1'b1, 12'h504, {29'h0, c});
            @(negedge mclk_i);
            check("rcfg", {29'h0, rcfg}, {29'h0, cl[i]});
            s = (cl[i] == 3'h7) ? 32'h100 : (32'h1 << (cl[i] + 3'h1));
            s[9] = (i < 3);
            rd(12'h508, s, 1'b0);
        end
    endtask : t_copy

    // misaligned, unmapped and read-only accesses are refused
    task automatic t_refuse;
        rd(12'h4a2, 32'h0, 1'b1);
        rd(12'h890, 32'h0, 1'b1);
        bus(1'b1, 12'h4a0, 32'hff);
        check("werr", {31'h0, err}, 32'h1);
        rd(12'h4a0, 32'h3, 1'b0);
    endtask : t_refuse

    // fifteen good query reads so far; a control write clears the count
    task automatic t_count;
        rd(12'h50c, 32'hf, 1'b0);
        bus(1'b1, 12'h500, 32'h2);
        check("clr_err", {31'h0, err}, 32'h0);
        rd(12'h50c, 32'h0, 1'b0);
        check("mux_clr", {31'h0, mux_v}, 32'h0);
    endtask : t_count

    // reset, then the scenarios in order
    initial begin
        repeat (20) @(posedge mclk_i);
        rstn_i <= 1'b1;
        @(negedge mclk_i);
        check("rcfg_rst", {29'h0, rcfg}, 32'h7);
        t_table();
        t_variant();
        t_copy();
        t_refuse();
        t_count();
        test_done();
    end
endmodule : tb_query_table_burst_partition_info

`default_nettype wire
